// ### rtl/pllcs_top.sv
// Contract
// - Flag register reset value follows reset cause
// - External stop flag sticky until software clears
// - Watchdog reset flag read-only, marks watchdog reset
// - Software reset flag read-only, marks halt reset
// - Crystal stops once aux clock present, selected
// - Stop enable reads zero until aux runs
// - Divide-by-16 select; toggling raises interrupt
// - Aux status set only when aux selected; the code also sets it in low-power wait with the wait clock choice set
// - PLL select picks PLL or crystal clock
// - Hardware clears PLL select in four cases
// - Aux clock selection overrides all sources
// - Multiplier code maps to 14, 10, 8, 6
// - Divider code plus one; 111 bypasses PLL
// - PLL register resets to multiplier 00, divider 111
// - Halt stops oscillator, clock held high
// - Watchdog enabled keeps oscillator running on halt
// - Low-power wait forces divide-by-16 or aux
// - Aux request effective only with clock present
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "pllcs_defines.svh"
module pllcs_top #(
   parameter int AW = 12,
   parameter int AUX_WIN_CYC = `PLLCS_AUX_WINDOW_NS / `PLLCS_CLK_PERIOD_NS,
   parameter int GUARD_CYC = (`PLLCS_SWITCH_GUARD_NS + `PLLCS_CLK_PERIOD_NS - 1)
      / `PLLCS_CLK_PERIOD_NS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rst_cause_wdg_i,
   input wire logic rst_cause_sw_i,
   input wire logic aux_clock_pin_i,
   input wire logic ext_stop_n_i,
   input wire logic wait_for_interrupt_i,
   input wire logic wake_i,
   input wire logic halt_i,
   input wire logic watchdog_enabled_i,
   output var pllcs_pkg::pllcs_src_t sys_clk_src_o,
   output logic sys_clk_run_o,
   output logic oscillator_enable_o,
   output logic oscillator_clock_high_o,
   output logic pll_enable_o,
   output logic [3:0] pll_factor_o,
   output logic [2:0] pll_divider_code_o,
   output logic clk_event_irq_o,
   output logic software_reset_req_o
);
   // Bus slave state
   logic ack_r;
   logic [7:0] rdat_r;
   // Control register (low-power wait, aux request, software reset enable)
   logic sw_rst_en_r;
   logic aux_clock_select_r;
   logic wait_clock_choice_r;
   logic low_power_wait_enable_r;
   // Clock flag register
   logic external_stop_flag_r;
   logic watchdog_reset_flag_r;
   logic software_reset_flag_r;
   logic crystal_stop_enable_pend_r; // Software asked for a crystal stop
   logic crystal_stop_enable_r; // Stop actually in force
   logic div16_select_r;
   logic aux_clock_status_r;
   logic pll_source_select_r;
   // PLL configuration register
   logic [1:0] pll_multiplier_code_r;
   logic [2:0] pll_divider_code_r;
   // Operating state
   logic wait_lp_r; // In low-power wait
   logic halted_r; // Halted until reset
   logic stop_n_prev_r;
   logic aux_prev_r;
   logic [15:0] aux_cnt_r;
   logic aux_present_r;
   // Switch sequencer
   pllcs_pkg::pllcs_sw_t st_r;
   pllcs_pkg::pllcs_sw_t st_nxt;
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   pllcs_pkg::pllcs_src_t src_r;
   logic run_r;
   // Registered outputs
   logic osc_en_r;
   logic osc_high_r;
   logic pll_en_r;
   logic [3:0] factor_r;
   logic [2:0] divc_r;
   logic irq_r;
   logic swrst_r;

   // Pins cross the filtered synchroniser; aux goes in inverted so its reset level is idle low
   logic [1:0] pin_s;
   pllcs_sync3 #(.W(2)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({~aux_clock_pin_i, ext_stop_n_i}),
      .q_o(pin_s)
   );
   wire aux_pin_s = ~pin_s[1];
   wire stop_n_s = pin_s[0];

   // Bus decode; one word per register, low byte carries the data
   wire req = wb_cyc_i & wb_stb_i;
   wire [AW-3:0] widx = wb_adr_i[AW-1:2];
   wire hit_ctrl = (widx == (AW-2)'(`PLLCS_IDX_CTRL));
   wire hit_flag = (widx == (AW-2)'(`PLLCS_IDX_FLAG));
   wire hit_pll = (widx == (AW-2)'(`PLLCS_IDX_PLL));
   // Write lands on the edge where the master sees ack
   wire wr = req & wb_we_i & ack_r & wb_sel_i[0];
   wire wr_ctrl = wr & hit_ctrl;
   wire wr_flag = wr & hit_flag;
   wire wr_pll = wr & hit_pll;
   wire [7:0] wd = wb_dat_i[7:0];

   // Read views; unused and reserved bits read zero
   wire [7:0] flag_rd = {external_stop_flag_r, watchdog_reset_flag_r,
      software_reset_flag_r, crystal_stop_enable_r, div16_select_r,
      aux_clock_status_r, 1'b0, pll_source_select_r};
   wire [7:0] pll_rd = {2'b00, pll_multiplier_code_r, 1'b0, pll_divider_code_r};
   wire [7:0] ctrl_rd = {4'h0, sw_rst_en_r, aux_clock_select_r,
      wait_clock_choice_r, low_power_wait_enable_r};
   // Unmapped addresses answer with zero
   wire [7:0] rd_sel = hit_flag ? flag_rd : hit_pll ? pll_rd : hit_ctrl ? ctrl_rd : 8'h00;

   // Events
   wire wait_entry = wait_for_interrupt_i & low_power_wait_enable_r;
   wire stop_exit = stop_n_s & ~stop_n_prev_r;
   wire halt_sw = halt_i & sw_rst_en_r;
   wire halt_osc = halt_i & ~sw_rst_en_r & ~watchdog_enabled_i;
   wire xtal_stopped = crystal_stop_enable_r | halted_r;

   // Next values of software-visible bits
   wire div16_nxt = wr_flag ? wd[`PLLCS_FLAG_DIV16] : div16_select_r;
   wire [2:0] div_nxt = wr_pll ? wd[`PLLCS_PLL_DIV_HI:0] : pll_divider_code_r;
   wire [1:0] mul_nxt = wr_pll ? wd[`PLLCS_PLL_MUL_HI:`PLLCS_PLL_MUL_LO]
      : pll_multiplier_code_r;
   // Hardware clears win over a software set to keep an unlocked PLL off
   wire pll_hw_clr = (div_nxt == `PLLCS_DIV_OFF) | xtal_stopped | wait_entry
      | ~div16_nxt;
   wire pll_sel_nxt = pll_hw_clr ? 1'b0
      : (wr_flag ? wd[`PLLCS_FLAG_PLL_SEL] : pll_source_select_r);
   // A set by the stop exit wins over a software clear in the same cycle
   wire ext_stop_nxt = stop_exit
      | (external_stop_flag_r & ~(wr_flag & ~wd[`PLLCS_FLAG_EXT_STOP]));
   // Writing zero drops a pending stop, so a careless read-modify-write cancels it
   wire pend_nxt = wr_flag ? wd[`PLLCS_FLAG_CRYSTAL_STOP_ENABLE] : crystal_stop_enable_pend_r;
   wire crystal_stop_enable_nxt = pend_nxt & aux_clock_status_r;
   // Aux request counts only while the pin really toggles
   wire aux_req = aux_clock_select_r | (wait_lp_r & wait_clock_choice_r);
   wire aux_st_nxt = aux_req & aux_present_r;
   wire irq_nxt = (div16_nxt != div16_select_r)
      | (aux_st_nxt != aux_clock_status_r);

   // Source the mux should settle on; aux first
   wire pllcs_pkg::pllcs_src_t tgt = aux_clock_status_r ? pllcs_pkg::src_aux
      : (~div16_select_r | wait_lp_r) ? pllcs_pkg::src_div16
      : (pll_source_select_r & pll_en_r) ? pllcs_pkg::src_pll
      : pllcs_pkg::src_xtal;
   wire pll_en_nxt = div16_select_r & ~wait_lp_r & ~xtal_stopped
      & (pll_divider_code_r != `PLLCS_DIV_OFF);
   wire [3:0] factor_nxt = (pll_multiplier_code_r == 2'h0) ? `PLLCS_MUL_F00
      : (pll_multiplier_code_r == 2'h1) ? `PLLCS_MUL_F01
      : (pll_multiplier_code_r == 2'h2) ? `PLLCS_MUL_F10 : `PLLCS_MUL_F11;
   // Clock is frozen high in stop and halt; gated while the mux changes
   wire run_nxt = (st_nxt == pllcs_pkg::st_idle) & stop_n_s & ~halted_r;

   // Switch sequencer: gate off, wait, swap, wait, gate on, so no runt pulse escapes
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      case (st_r)
         pllcs_pkg::st_idle: begin
            if (tgt != src_r) begin
               st_nxt = pllcs_pkg::st_drain;
               cnt_nxt = 8'(GUARD_CYC);
            end
         end
         pllcs_pkg::st_drain: begin
            if (cnt_r == 8'h00) begin
               st_nxt = pllcs_pkg::st_swap;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         pllcs_pkg::st_swap: begin
            st_nxt = pllcs_pkg::st_fill;
            cnt_nxt = 8'(GUARD_CYC);
         end
         pllcs_pkg::st_fill: begin
            if (cnt_r == 8'h00) begin
               st_nxt = pllcs_pkg::st_idle;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         default: begin
            st_nxt = pllcs_pkg::st_idle;
            cnt_nxt = 8'h00;
         end
      endcase
   end

   // Bus handshake: ack one cycle after the request, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdat_r <= 8'h00;
      end else begin
         ack_r <= req & ~ack_r;
         rdat_r <= rd_sel;
      end
   end

   // Control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {sw_rst_en_r, aux_clock_select_r, wait_clock_choice_r,
            low_power_wait_enable_r} <= `PLLCS_CTRL_RST;
      end else if (wr_ctrl) begin
         sw_rst_en_r <= wd[`PLLCS_CTRL_SW_RST_EN];
         aux_clock_select_r <= wd[`PLLCS_CTRL_AUX_SEL];
         wait_clock_choice_r <= wd[`PLLCS_CTRL_WAIT_CHOICE];
         low_power_wait_enable_r <= wd[`PLLCS_CTRL_LP_WAIT];
      end
   end

   // Clock flag register; reset pattern taken from the cause lines
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         external_stop_flag_r <= 1'b0;
         watchdog_reset_flag_r <= rst_cause_wdg_i;
         software_reset_flag_r <= rst_cause_sw_i & ~rst_cause_wdg_i;
         crystal_stop_enable_pend_r <= 1'b0;
         crystal_stop_enable_r <= 1'b0;
         div16_select_r <= 1'b1;
         aux_clock_status_r <= 1'b0;
         pll_source_select_r <= 1'b0;
      end else begin
         external_stop_flag_r <= ext_stop_nxt;
         crystal_stop_enable_pend_r <= pend_nxt;
         crystal_stop_enable_r <= crystal_stop_enable_nxt;
         div16_select_r <= div16_nxt;
         aux_clock_status_r <= aux_st_nxt;
         pll_source_select_r <= pll_sel_nxt;
      end
   end

   // PLL configuration register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pll_multiplier_code_r <= `PLLCS_MUL_RST;
         pll_divider_code_r <= `PLLCS_DIV_OFF;
      end else begin
         pll_multiplier_code_r <= mul_nxt;
         pll_divider_code_r <= div_nxt;
      end
   end

   // Low-power wait and halt state; only reset leaves halt
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wait_lp_r <= 1'b0;
         halted_r <= 1'b0;
         stop_n_prev_r <= 1'b1;
      end else begin
         if (wait_entry) begin
            wait_lp_r <= 1'b1;
         end else if (wake_i) begin
            wait_lp_r <= 1'b0;
         end
         if (halt_osc) begin
            halted_r <= 1'b1;
         end
         stop_n_prev_r <= stop_n_s;
      end
   end

   // Aux presence: an edge must arrive within the window; a slow aux
   // clock beyond the window is reported absent
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aux_prev_r <= 1'b0;
         aux_cnt_r <= 16'h0000;
         aux_present_r <= 1'b0;
      end else begin
         aux_prev_r <= aux_pin_s;
         if (aux_pin_s != aux_prev_r) begin
            aux_cnt_r <= 16'h0000;
            aux_present_r <= 1'b1;
         end else if (aux_cnt_r >= 16'(AUX_WIN_CYC)) begin
            aux_present_r <= 1'b0;
         end else begin
            aux_cnt_r <= aux_cnt_r + 16'h0001;
         end
      end
   end

   // Sequencer state and mux select
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= pllcs_pkg::st_idle;
         cnt_r <= 8'h00;
         src_r <= pllcs_pkg::src_xtal;
         run_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         if (st_r == pllcs_pkg::st_swap) begin
            src_r <= tgt;
         end
         run_r <= run_nxt;
      end
   end

   // Output flops for the oscillator and PLL controls
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_en_r <= 1'b1;
         osc_high_r <= 1'b0;
         pll_en_r <= 1'b0;
         factor_r <= `PLLCS_MUL_F00;
         divc_r <= `PLLCS_DIV_OFF;
         irq_r <= 1'b0;
         swrst_r <= 1'b0;
      end else begin
         osc_en_r <= ~xtal_stopped & ~halt_osc;
         osc_high_r <= halted_r | halt_osc;
         pll_en_r <= pll_en_nxt;
         factor_r <= factor_nxt;
         divc_r <= pll_divider_code_r;
         irq_r <= irq_nxt;
         swrst_r <= halt_sw;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = {24'h000000, rdat_r};
   assign sys_clk_src_o = src_r;
   assign sys_clk_run_o = run_r;
   assign oscillator_enable_o = osc_en_r;
   assign oscillator_clock_high_o = osc_high_r;
   assign pll_enable_o = pll_en_r;
   assign pll_factor_o = factor_r;
   assign pll_divider_code_o = divc_r;
   assign clk_event_irq_o = irq_r;
   assign software_reset_req_o = swrst_r;
endmodule : pllcs_top
`default_nettype wire

// ### shared/pllcs_defines.svh
`ifndef PLLCS_DEFINES_SVH
`define PLLCS_DEFINES_SVH
// Register indices; byte address is four times the index
`define PLLCS_IDX_CTRL 10'h0F0
`define PLLCS_IDX_FLAG 10'h0F2
`define PLLCS_IDX_PLL 10'h0F6
// Clock flag register bit positions
`define PLLCS_FLAG_EXT_STOP 7
`define PLLCS_FLAG_WDG 6
`define PLLCS_FLAG_SW 5
`define PLLCS_FLAG_CRYSTAL_STOP_ENABLE 4
`define PLLCS_FLAG_DIV16 3
`define PLLCS_FLAG_AUX_ST 2
`define PLLCS_FLAG_PLL_SEL 0
// Control register bit positions
`define PLLCS_CTRL_SW_RST_EN 3
`define PLLCS_CTRL_AUX_SEL 2
`define PLLCS_CTRL_WAIT_CHOICE 1
`define PLLCS_CTRL_LP_WAIT 0
// PLL configuration field positions
`define PLLCS_PLL_MUL_HI 5
`define PLLCS_PLL_MUL_LO 4
`define PLLCS_PLL_DIV_HI 2
// Reset values
`define PLLCS_CTRL_RST 4'h0
`define PLLCS_MUL_RST 2'h0
`define PLLCS_DIV_OFF 3'h7
// Multiplication factors per code
`define PLLCS_MUL_F00 4'hA
`define PLLCS_MUL_F01 4'h6
`define PLLCS_MUL_F10 4'hE
`define PLLCS_MUL_F11 4'h8
// Timing
`define PLLCS_CLK_PERIOD_NS 40
`define PLLCS_AUX_WINDOW_NS 2000
`define PLLCS_SWITCH_GUARD_NS 160
`endif

// ### shared/pllcs_pkg.sv
package pllcs_pkg;
   // System clock source driven to the clock mux
   typedef enum logic [1:0] {src_xtal, src_div16, src_pll, src_aux} pllcs_src_t;
   // Glitch-free switch sequencer
   typedef enum logic [1:0] {st_idle, st_drain, st_swap, st_fill} pllcs_sw_t;
endpackage : pllcs_pkg

// ### rtl/pllcs_sync3.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; output moves once stages two and three agree
module pllcs_sync3 #(
   parameter int W = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         logic s1_r; // Metastable stage, read only by s2_r
         logic s2_r;
         logic s3_r;
         logic q_r;
         // Shift chain; a one-sample disagreement is filtered out
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               s1_r <= 1'b1;
               s2_r <= 1'b1;
               s3_r <= 1'b1;
               q_r <= 1'b1;
            end else begin
               s1_r <= d_i[g];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  q_r <= s3_r;
               end
            end
         end
         assign q_o[g] = q_r;
      end
   endgenerate
endmodule : pllcs_sync3
`default_nettype wire

// ### bench/pllcs_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the clock selection block
module pllcs_top_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic ext_stop_n_i,
   input wire logic halt_i,
   input wire logic watchdog_enabled_i,
   input wire pllcs_pkg::pllcs_src_t sys_clk_src_o,
   input wire logic sys_clk_run_o,
   input wire logic oscillator_enable_o,
   input wire logic oscillator_clock_high_o,
   input wire logic pll_enable_o,
   input wire logic [3:0] pll_factor_o,
   input wire logic [2:0] pll_divider_code_o,
   input wire logic clk_event_irq_o,
   input wire logic software_reset_req_o
);
   // One clock domain, so clocking and reset are given once
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_factor_legal: assert property (pll_factor_o inside {4'hE, 4'hA, 4'h8, 4'h6})
      else $error("pll factor outside the four legal values");
   a_div_off_pll: assert property (pll_divider_code_o == 3'h7 [*2] |-> !pll_enable_o)
      else $error("pll running with divider bypass code");
   // Source may only move while the clock gate is shut, so no runt pulse leaks out
   a_swap_gated: assert property ($changed(sys_clk_src_o) |-> !sys_clk_run_o && !$past(sys_clk_run_o))
      else $error("source changed with clock gate open");
   a_halt_cause: assert property ($rose(oscillator_clock_high_o) |->
      $past(halt_i) && !$past(watchdog_enabled_i))
      else $error("oscillator held high without halt");
   a_halt_sticky: assert property (oscillator_clock_high_o |-> !oscillator_enable_o
      ##1 oscillator_clock_high_o)
      else $error("halt state left without reset");
   a_wdg_keeps_osc: assert property (halt_i && watchdog_enabled_i && !oscillator_clock_high_o
      |=> !oscillator_clock_high_o && oscillator_enable_o)
      else $error("oscillator stopped with watchdog enabled");
   a_swrst_cause: assert property (software_reset_req_o |-> $past(halt_i))
      else $error("software reset request without halt");
   a_irq_pulse: assert property (clk_event_irq_o |=> !clk_event_irq_o)
      else $error("clock event interrupt longer than one cycle");
   a_stop_freezes: assert property (!ext_stop_n_i [*7] |-> !sys_clk_run_o)
      else $error("system clock runs during stop");
   c_aux: cover property (sys_clk_src_o == pllcs_pkg::src_aux);
   c_pll: cover property (sys_clk_src_o == pllcs_pkg::src_pll);
   c_swrst: cover property (software_reset_req_o);
   c_halt: cover property (oscillator_clock_high_o);
endmodule : pllcs_top_asserts
`default_nettype wire

// ### bench/pllcs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pllcs_defines.svh"
// Register-level bench for the clock selection block
module pllcs_tb_top;
   localparam logic [11:0] A_CTL = {`PLLCS_IDX_CTRL, 2'h0};
   localparam logic [11:0] A_FLG = {`PLLCS_IDX_FLAG, 2'h0};
   localparam logic [11:0] A_PLL = {`PLLCS_IDX_PLL, 2'h0};
   logic clk_i, rst_i, cyc, stb, we, wdg_c, sw_c, aux_pin, stop_n, wd_en, aux_on;
   logic ack, run, osc_en, osc_hi, pll_en, irq, swrst;
   logic [11:0] adr;
   logic [31:0] wdat, rdat, dat_o;
   logic [2:0] pls; // Halt, wait and wake strobes
   logic [1:0] aux_div; // Aux pin runs at a quarter of the bus clock
   logic [3:0] fac;
   logic [2:0] dvc;
   logic [3:0] sel; // Byte enables, driven with the request
   logic [3:0] tbl [4] = '{4'hA, 4'h6, 4'hE, 4'h8}; // Factor per multiplier code
   pllcs_pkg::pllcs_src_t src;
   int n_mismatch, n_checks, n_irq, k, m;
   pllcs_top uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .rst_cause_wdg_i(wdg_c), .rst_cause_sw_i(sw_c), .aux_clock_pin_i(aux_pin),
      .ext_stop_n_i(stop_n), .wait_for_interrupt_i(pls[1]), .wake_i(pls[2]),
      .halt_i(pls[0]), .watchdog_enabled_i(wd_en), .sys_clk_src_o(src),
      .sys_clk_run_o(run), .oscillator_enable_o(osc_en), .oscillator_clock_high_o(osc_hi),
      .pll_enable_o(pll_en), .pll_factor_o(fac), .pll_divider_code_o(dvc),
      .clk_event_irq_o(irq), .software_reset_req_o(swrst));
   // Free-running bus clock
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // Aux pin toggles only while enabled, otherwise it rests low
   always @(posedge clk_i) begin
      aux_div <= aux_div + 2'h1;
      aux_pin <= aux_on & aux_div[1];
   end
   // Counts interrupt pulses for later comparison
   always @(posedge clk_i) if (irq === 1'b1) n_irq <= n_irq + 1;
   task automatic ck(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : ck
   // Classic single cycle; held until ack is sampled high
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= a;
      wdat <= {24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      ck("register", rdat, {24'h0, e});
   endtask : rd
   // Holds reset for 16 cycles with the given cause lines
   task automatic rst(input logic w, input logic s);
      rst_i <= 1'b1;
      wdg_c <= w;
      sw_c <= s;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wdg_c <= 1'b0;
      sw_c <= 1'b0;
   endtask : rst
   // Bounded wait, since a switch takes guard cycles on both sides
   task automatic wsrc(input pllcs_pkg::pllcs_src_t e);
      for (int i = 0; i < 60 && src !== e; i++) @(posedge clk_i);
      ck("source", src, e);
   endtask : wsrc
   task automatic pulse(input logic [2:0] p);
      @(posedge clk_i);
      pls <= p;
      @(posedge clk_i);
      pls <= 3'h0;
      @(posedge clk_i);
   endtask : pulse
   task automatic tally_and_finish;
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   // Guards against a hung handshake
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      {rst_i, cyc, stb, we, wdg_c, sw_c, stop_n, wd_en, aux_on} = 9'h104;
      {adr, wdat, pls, aux_div, aux_pin, sel} = '0;
      rst(1'b0, 1'b0);
      rd(A_FLG, 8'h08);
      rd(A_PLL, 8'h07);
      ck("factor", fac, 4'hA);
      rd(12'h004, 8'h00);
      wr(A_FLG, 8'hFF);
      rd(A_FLG, 8'h08);
      for (m = 0; m < 4; m++) begin
         wr(A_PLL, 8'(m * 17));
         rd(A_PLL, 8'(m * 17));
         ck("factor", fac, tbl[m]);
         ck("divider", dvc, m);
         ck("pll on", pll_en, 1'b1);
      end
      wr(A_PLL, 8'h01);
      repeat (8) @(posedge clk_i);
      wr(A_FLG, 8'h09);
      wsrc(pllcs_pkg::src_pll);
      k = n_irq;
      wr(A_FLG, 8'h00);
      rd(A_FLG, 8'h00);
      wsrc(pllcs_pkg::src_div16);
      ck("pll on", pll_en, 1'b0);
      wr(A_FLG, 8'h01);
      rd(A_FLG, 8'h00);
      wr(A_FLG, 8'h08);
      wsrc(pllcs_pkg::src_xtal);
      ck("irq count", n_irq - k, 2);
      wr(A_FLG, 8'h09);
      wsrc(pllcs_pkg::src_pll);
      wr(A_CTL, 8'h01);
      pulse(3'h2);
      rd(A_FLG, 8'h08);
      wsrc(pllcs_pkg::src_div16);
      ck("pll on", pll_en, 1'b0);
      pulse(3'h4);
      wsrc(pllcs_pkg::src_xtal);
      wr(A_CTL, 8'h00);
      wr(A_FLG, 8'h19);
      rd(A_FLG, 8'h09);
      wr(A_FLG, 8'h09);
      wsrc(pllcs_pkg::src_pll);
      wr(A_CTL, 8'h04);
      rd(A_FLG, 8'h09);
      aux_on <= 1'b1;
      repeat (20) @(posedge clk_i);
      rd(A_FLG, 8'h0D);
      wsrc(pllcs_pkg::src_aux);
      ck("osc on", osc_en, 1'b1);
      wr(A_FLG, 8'h1D);
      repeat (4) @(posedge clk_i);
      rd(A_FLG, 8'h1C);
      ck("osc on", osc_en, 1'b0);
      aux_on <= 1'b0;
      rst(1'b0, 1'b0);
      stop_n <= 1'b0;
      repeat (8) @(posedge clk_i);
      ck("run", run, 1'b0);
      stop_n <= 1'b1;
      repeat (12) @(posedge clk_i);
      rd(A_FLG, 8'h88);
      rd(A_FLG, 8'h88);
      wr(A_FLG, 8'h08);
      rd(A_FLG, 8'h08);
      wr(A_CTL, 8'h08);
      pulse(3'h1);
      ck("swrst", swrst, 1'b1);
      rst(1'b0, 1'b1);
      rd(A_FLG, 8'h28);
      wd_en <= 1'b1;
      pulse(3'h1);
      ck("osc high", osc_hi, 1'b0);
      ck("osc on", osc_en, 1'b1);
      wd_en <= 1'b0;
      pulse(3'h1);
      repeat (5) @(posedge clk_i);
      ck("osc high", osc_hi, 1'b1);
      ck("osc on", osc_en, 1'b0);
      rst(1'b1, 1'b1);
      rd(A_FLG, 8'h48);
      ck("osc on", osc_en, 1'b1);
      aux_on <= 1'b1;
      repeat (20) @(posedge clk_i);
      wr(A_CTL, 8'h03);
      pulse(3'h2);
      rd(A_FLG, 8'h4C);
      wsrc(pllcs_pkg::src_aux);
      pulse(3'h4);
      rd(A_FLG, 8'h48);
      wsrc(pllcs_pkg::src_xtal);
      tally_and_finish();
   end
endmodule : pllcs_tb_top
bind pllcs_top pllcs_top_asserts chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .ext_stop_n_i, .halt_i, .watchdog_enabled_i, .sys_clk_src_o, .sys_clk_run_o,
   .oscillator_enable_o, .oscillator_clock_high_o, .pll_enable_o, .pll_factor_o,
   .pll_divider_code_o, .clk_event_irq_o, .software_reset_req_o);
`default_nettype wire
